//--- prog_link_regs.svh
// constants for the serial programming link and identifier readout
`ifndef PROG_LINK_REGS_SVH
`define PROG_LINK_REGS_SVH
// control codes, sent lsb first ahead of each frame
`define CODE_FORCED 4'h0
`define CODE_READOUT 4'h1
// frame geometry in clock pulses
`define CODE_PULSES 5'd4
`define FRAME_PULSES 5'd28
`define RD_OE_LAST 5'd4
`define RD_DRIVE_FIRST 5'd12
`define RD_DRIVE_LAST 5'd27
`define RD_CAP_FIRST 5'd13
// forced instruction words
`define W_NOP 24'h000000
`define W_GOTO_200 24'h040200
`define W_LD_PAGE 24'h200800
`define W_WR_PAGE 24'h8802a0
`define W_LD_OFS 24'h207f00
`define W_LD_PTR 24'h207841
`define W_TABLE_READ_LOW_INSTR 24'hba0890
// instruction decode fields
`define OP_MOV_LIT 4'h2
`define REG_W0 4'h0
`define REG_W1 4'h1
// address map
`define ID_ADDR 24'h8007f0
`define READOUT_ADDR 16'h0784
`define BLANK_WORD 16'hffff
// readout sequence layout
`define SEQ_LAST 4'd12
`define SEQ_READ_IDX 4'd11
// timing
`define REF_CLK_NS 40
`define LINK_HALF_CYC 4
`define SETTLE_NS 1000
`define EXIT_GAP_NS 1000
`endif

//--- prog_link_pkg.sv
// types shared by both ends of the programming link
package prog_link_pkg;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_ENTER = 3'h1,
    HS_FRAME = 3'h3,
    HS_EXITW = 3'h2,
    HS_DONE = 3'h6
  } host_state_t;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_VERIFY_EXEC = 3'h1,
    PH_ERASE = 3'h3,
    PH_PROG_CODE = 3'h2,
    PH_PROG_CONFIG = 3'h6,
    PH_VERIFY_ALL = 3'h7,
    PH_END = 3'h5
  } prog_phase_t;

  typedef enum logic [3:0] {
    sanity_check_cmd = 4'h0,
    read_ident_regs_cmd = 4'h1,
    read_code_cmd = 4'h2,
    program_row_cmd = 4'h3,
    program_word_cmd = 4'h4,
    query_blank_cmd = 4'h5,
    query_version_cmd = 4'h6
  } exec_cmd_t;
endpackage : prog_link_pkg

//--- prog_link_if.sv
// wires between programmer and device, with the pulled-up data pin resolved
`timescale 1ns/1ns
`default_nettype none
interface prog_link_if;
  logic prog_serial_clock;
  logic master_clear_pin;
  logic host_data_o;
  logic host_data_oe_n;
  logic dev_data_o;
  logic dev_data_oe_n;
  logic prog_serial_data;

  // pin level: the host if it enables, else the device if it enables, else the pull-up
  assign prog_serial_data = !host_data_oe_n ? host_data_o : (!dev_data_oe_n ? dev_data_o : 1'b1);

  modport host (
    output prog_serial_clock,
    output master_clear_pin,
    output host_data_o,
    output host_data_oe_n,
    input prog_serial_data
  );
  modport device (
    input prog_serial_clock,
    input master_clear_pin,
    output dev_data_o,
    output dev_data_oe_n,
    input prog_serial_data
  );
endinterface : prog_link_if
`default_nettype wire

//--- prog_exec_device.sv
// device end: serial frame receiver, forced-instruction subset and readout shifter
`timescale 1ns/1ns
`default_nettype none
`include "prog_link_regs.svh"
module prog_exec_device #(
  parameter logic [15:0] ID_WORD = 16'h005a // arbitrary value
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // link
  prog_link_if.device link,
  // executive command check
  input wire logic [3:0] i_exec_cmd,
  input wire logic i_exec_cmd_valid,
  output logic o_exec_cmd_ok,
  // status
  output logic o_prog_mode,
  output logic [15:0] o_readout
);
  logic clk_s1, clk_s2, clk_prev;
  logic dat_s1, dat_s2;
  logic master_clear_pin_s1, master_clear_pin_s2;
  logic [4:0] rcnt_r;
  logic [27:0] sh_r;
  logic [27:0] sh_nxt;
  logic [3:0] code_r;
  logic [15:0] w0_r, w1_r, readout_r;
  logic [7:0] page_r;
  logic dout_r, oe_n_r, cmd_ok_r;

  // pins are foreign to this clock: two flops each
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {clk_s1, clk_s2, clk_prev} <= 3'h0;
      {dat_s1, dat_s2} <= 2'h3;
      {master_clear_pin_s1, master_clear_pin_s2} <= 2'h0;
    end else begin
      {clk_s1, clk_s2, clk_prev} <= {link.prog_serial_clock, clk_s1, clk_s2};
      {dat_s1, dat_s2} <= {link.prog_serial_data, dat_s1};
      {master_clear_pin_s1, master_clear_pin_s2} <= {link.master_clear_pin, master_clear_pin_s1};
    end
  end

  // edge and frame decode
  wire rise = clk_s2 & ~clk_prev;
  wire fall = ~clk_s2 & clk_prev;
  wire last_rise = rise && (rcnt_r == `FRAME_PULSES - 5'd1);
  wire frame_end = fall && (rcnt_r == `FRAME_PULSES);
  wire [23:0] word = sh_nxt[27:4];
  wire exec_now = last_rise && (code_r == `CODE_FORCED);
  wire is_mov = word[23:20] == `OP_MOV_LIT;
  wire [23:0] rd_addr = {page_r, w0_r};
  wire [15:0] mem_rd = (rd_addr == `ID_ADDR) ? ID_WORD : `BLANK_WORD;
  wire in_read = (code_r == `CODE_READOUT) && (rcnt_r >= `CODE_PULSES);
  wire drive_bit = fall && in_read && (rcnt_r >= `RD_DRIVE_FIRST) && (rcnt_r <= `RD_DRIVE_LAST);
  wire [3:0] bit_idx = 4'(rcnt_r - `RD_DRIVE_FIRST);
  // let go as the last pulse rises, so the programmer can retake the line at its fall without overlap
  wire release_now = last_rise && in_read;
  assign sh_nxt = {dat_s2, sh_r[27:1]};

  // frame counter: bits arrive lsb first on rising edges
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rcnt_r <= 5'h0;
      sh_r <= 28'h0;
      code_r <= `CODE_FORCED;
    end else if (!master_clear_pin_s2) begin
      rcnt_r <= 5'h0;
    end else if (rise && rcnt_r < `FRAME_PULSES) begin
      rcnt_r <= rcnt_r + 5'd1;
      sh_r <= sh_nxt;
      if (rcnt_r == `CODE_PULSES - 5'd1)
        code_r <= sh_nxt[27:24];
    end else if (frame_end) begin
      rcnt_r <= 5'h0;
    end
  end

  // forced instructions: only the moves, page write and table read matter here
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      w0_r <= 16'h0;
      w1_r <= 16'h0;
      page_r <= 8'h0;
      readout_r <= 16'h0;
    end else if (exec_now) begin
      if (is_mov && word[3:0] == `REG_W0)
        w0_r <= word[19:4];
      if (is_mov && word[3:0] == `REG_W1)
        w1_r <= word[19:4];
      if (word == `W_WR_PAGE)
        page_r <= w0_r[7:0];
      if (word == `W_TABLE_READ_LOW_INSTR && w1_r == `READOUT_ADDR)
        readout_r <= mem_rd;
    end
  end

  // readout shifter: bits change on falling edges, line released as the last pulse rises
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dout_r <= 1'b1;
      oe_n_r <= 1'b1;
    end else if (!master_clear_pin_s2 || frame_end || release_now) begin
      oe_n_r <= 1'b1;
    end else if (drive_bit) begin
      dout_r <= readout_r[bit_idx];
      oe_n_r <= 1'b0;
    end
  end

  // executive command acceptance
  localparam logic [3:0] query_version_cmd_val = prog_link_pkg::query_version_cmd;
  wire cmd_known = i_exec_cmd <= query_version_cmd_val;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn)
      cmd_ok_r <= 1'b0;
    else
      cmd_ok_r <= i_exec_cmd_valid && cmd_known;
  end

  assign link.dev_data_o = dout_r;
  assign link.dev_data_oe_n = oe_n_r;
  assign o_exec_cmd_ok = cmd_ok_r;
  assign o_prog_mode = master_clear_pin_s2;
  assign o_readout = readout_r;
endmodule : prog_exec_device
`default_nettype wire

//--- prog_exec_host.sv
// programmer end: reads the identifier word, decides executive presence, exits mode
`timescale 1ns/1ns
`default_nettype none
`include "prog_link_regs.svh"
module prog_exec_host #(
  parameter logic [15:0] ID_EXPECTED = 16'h005a, // arbitrary value
  parameter int HALF_CYC = `LINK_HALF_CYC,
  parameter int SETTLE_CYC = (`SETTLE_NS + `REF_CLK_NS - 1) / `REF_CLK_NS,
  parameter int EXIT_CYC = (`EXIT_GAP_NS + `REF_CLK_NS - 1) / `REF_CLK_NS
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // user control
  input wire logic i_start,
  input wire logic i_phase_next,
  // user status
  output logic o_busy,
  output logic o_done,
  output logic o_exec_resident,
  output logic o_load_exec_needed,
  output logic [15:0] o_id_word,
  output prog_link_pkg::prog_phase_t o_phase,
  output logic o_ram_stale,
  // link
  prog_link_if.host link
);
  // counts must fit the timer; the half period must cover the device's three-cycle
  // pin delay for capture, yet end before it releases the line after the last rise
  if (HALF_CYC < 3 || HALF_CYC > 5 || SETTLE_CYC < 1 || EXIT_CYC < 1 || SETTLE_CYC > 65535 || EXIT_CYC > 65535)
  begin : g_bad
    $error("prog_exec_host: timing parameter out of range");
  end

  prog_link_pkg::host_state_t st_r;
  prog_link_pkg::prog_phase_t phase_r;
  logic [15:0] tmr_r;
  logic [7:0] half_r;
  logic [3:0] idx_r;
  logic [4:0] pcnt_r;
  logic [27:0] tx_r;
  logic sclk_r, dout_r, oe_n_r, master_clear_pin_r;
  logic [15:0] id_r;
  logic resident_r, done_r, stale_r;
  logic d_s1, d_s2;

  // frame table, control code in the low nibble, sent lsb first
  function automatic logic [27:0] frame_of(input logic [3:0] idx);
    logic [27:0] f;
    f = {`W_NOP, `CODE_FORCED};
    case (idx)
      4'd1: f = {`W_GOTO_200, `CODE_FORCED};
      4'd3: f = {`W_LD_PAGE, `CODE_FORCED};
      4'd4: f = {`W_WR_PAGE, `CODE_FORCED};
      4'd5: f = {`W_LD_OFS, `CODE_FORCED};
      4'd6: f = {`W_LD_PTR, `CODE_FORCED};
      4'd8: f = {`W_TABLE_READ_LOW_INSTR, `CODE_FORCED};
      `SEQ_READ_IDX: f = {`W_NOP, `CODE_READOUT};
      default: f = {`W_NOP, `CODE_FORCED};
    endcase
    return f;
  endfunction : frame_of

  // data pin back from the device is foreign to this clock
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn)
      {d_s1, d_s2} <= 2'h3;
    else
      {d_s1, d_s2} <= {link.prog_serial_data, d_s1};
  end

  // bit engine decode
  wire half_end = half_r == 8'(HALF_CYC - 1);
  wire do_fall = (st_r == prog_link_pkg::HS_FRAME) && half_end && sclk_r;
  wire is_read = idx_r == `SEQ_READ_IDX;
  wire cap_bit = do_fall && is_read && pcnt_r >= `RD_CAP_FIRST;
  wire frame_last = pcnt_r == `FRAME_PULSES;
  wire seq_last = idx_r == `SEQ_LAST;
  wire [4:0] pcnt_nxt = pcnt_r + 5'd1;
  wire release_nxt = is_read && pcnt_nxt > `RD_OE_LAST;
  wire [27:0] next_frame = frame_of(4'(idx_r + 4'd1));
  wire [27:0] first_frame = frame_of(4'h0);
  wire settle_end = tmr_r == 16'(SETTLE_CYC - 1);
  wire exit_end = tmr_r == 16'(EXIT_CYC - 1);
  wire id_match = id_r == ID_EXPECTED;

  // sequencer: enter, send the table, wait the quiet gap, drop master clear
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= prog_link_pkg::HS_IDLE;
      tmr_r <= 16'h0;
      master_clear_pin_r <= 1'b0;
      idx_r <= 4'h0;
    end else begin
      unique case (st_r)
        prog_link_pkg::HS_IDLE, prog_link_pkg::HS_DONE: begin
          if (i_start) begin
            st_r <= prog_link_pkg::HS_ENTER;
            master_clear_pin_r <= 1'b1;
            tmr_r <= 16'h0;
            idx_r <= 4'h0;
          end
        end
        prog_link_pkg::HS_ENTER: begin
          tmr_r <= tmr_r + 16'd1;
          if (settle_end)
            st_r <= prog_link_pkg::HS_FRAME;
        end
        prog_link_pkg::HS_FRAME: begin
          if (do_fall && frame_last) begin
            if (seq_last) begin
              st_r <= prog_link_pkg::HS_EXITW;
              tmr_r <= 16'h0;
            end else begin
              idx_r <= idx_r + 4'd1;
            end
          end
        end
        prog_link_pkg::HS_EXITW: begin
          tmr_r <= tmr_r + 16'd1;
          if (exit_end) begin
            st_r <= prog_link_pkg::HS_DONE;
            master_clear_pin_r <= 1'b0;
          end
        end
        default: st_r <= prog_link_pkg::HS_IDLE;
      endcase
    end
  end

  // serial clock and data: data changes while clock is low, the device samples on the rise
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      half_r <= 8'h0;
      sclk_r <= 1'b0;
      pcnt_r <= 5'd1;
      tx_r <= 28'h0;
      dout_r <= 1'b1;
      oe_n_r <= 1'b1;
    end else if (st_r == prog_link_pkg::HS_ENTER) begin
      half_r <= 8'h0;
      pcnt_r <= 5'd1;
      tx_r <= first_frame;
      dout_r <= first_frame[0];
      oe_n_r <= 1'b0;
    end else if (st_r == prog_link_pkg::HS_FRAME) begin
      half_r <= half_end ? 8'h0 : half_r + 8'd1;
      if (half_end && !sclk_r) begin
        sclk_r <= 1'b1;
      end else if (do_fall) begin
        sclk_r <= 1'b0;
        if (frame_last) begin
          pcnt_r <= 5'd1;
          tx_r <= next_frame;
          dout_r <= next_frame[0];
          oe_n_r <= seq_last;
        end else begin
          pcnt_r <= pcnt_nxt;
          tx_r <= {1'b0, tx_r[27:1]};
          dout_r <= tx_r[1];
          oe_n_r <= release_nxt;
        end
      end
    end else begin
      sclk_r <= 1'b0;
      oe_n_r <= 1'b1; // quiet lines during the exit gap
    end
  end

  // identifier capture, lsb first, taken just before each falling edge
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn)
      id_r <= 16'h0;
    else if (cap_bit)
      id_r <= {d_s2, id_r[15:1]};
  end

  // presence decision and high-level order
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      resident_r <= 1'b0;
      done_r <= 1'b0;
      stale_r <= 1'b0;
      phase_r <= prog_link_pkg::PH_IDLE;
    end else if (i_start && !o_busy) begin
      resident_r <= 1'b0;
      done_r <= 1'b0;
      stale_r <= 1'b0;
      phase_r <= prog_link_pkg::PH_IDLE;
    end else if (st_r == prog_link_pkg::HS_EXITW && exit_end) begin
      done_r <= 1'b1;
      resident_r <= id_match;
      phase_r <= id_match ? prog_link_pkg::PH_VERIFY_EXEC : prog_link_pkg::PH_IDLE;
    end else if (i_phase_next && resident_r) begin
      stale_r <= 1'b1;
      unique case (phase_r)
        prog_link_pkg::PH_VERIFY_EXEC: phase_r <= prog_link_pkg::PH_ERASE;
        prog_link_pkg::PH_ERASE: phase_r <= prog_link_pkg::PH_PROG_CODE;
        prog_link_pkg::PH_PROG_CODE: phase_r <= prog_link_pkg::PH_PROG_CONFIG;
        prog_link_pkg::PH_PROG_CONFIG: phase_r <= prog_link_pkg::PH_VERIFY_ALL;
        prog_link_pkg::PH_VERIFY_ALL: phase_r <= prog_link_pkg::PH_END;
        default: phase_r <= phase_r;
      endcase
    end
  end

  // outputs
  assign o_busy = (st_r != prog_link_pkg::HS_IDLE) && (st_r != prog_link_pkg::HS_DONE);
  assign o_done = done_r;
  assign o_exec_resident = resident_r;
  assign o_load_exec_needed = done_r && !resident_r;
  assign o_id_word = id_r;
  assign o_phase = phase_r;
  assign o_ram_stale = stale_r;
  assign link.prog_serial_clock = sclk_r;
  assign link.master_clear_pin = master_clear_pin_r;
  assign link.host_data_o = dout_r;
  assign link.host_data_oe_n = oe_n_r;
endmodule : prog_exec_host
`default_nettype wire

//--- prog_link_assertions.sv
// concurrent checks on the programming link wires
`timescale 1ns/1ns
`default_nettype none
module prog_link_assertions #(
  parameter int EXIT_CYC = 2
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // link wires
  input wire logic prog_serial_clock,
  input wire logic master_clear_pin,
  input wire logic host_data_o,
  input wire logic host_data_oe_n,
  input wire logic dev_data_o,
  input wire logic dev_data_oe_n,
  input wire logic prog_serial_data
);
  logic [7:0] idle_cnt_r;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // quiet cycles since last clock pulse or host drive, saturating
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) idle_cnt_r <= 8'h00;
    else if (prog_serial_clock || !host_data_oe_n) idle_cnt_r <= 8'h00;
    else if (idle_cnt_r != 8'hff) idle_cnt_r <= idle_cnt_r + 8'h01;
  end
  // pulse shapes assume the default half period of 4 ref cycles
  property p_no_clk_idle;
    !master_clear_pin |-> !prog_serial_clock;
  endproperty
  a_no_clk_idle: assert property (p_no_clk_idle) else $error("link clock runs outside mode");
  property p_data_stable;
    prog_serial_clock |-> $stable(host_data_o) && $stable(host_data_oe_n);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("host data moved while clock high");
  property p_high_len;
    $rose(prog_serial_clock) |-> prog_serial_clock[*4] ##1 !prog_serial_clock;
  endproperty
  a_high_len: assert property (p_high_len) else $error("clock high phase length wrong");
  property p_low_len;
    $fell(prog_serial_clock) |-> !prog_serial_clock[*4];
  endproperty
  a_low_len: assert property (p_low_len) else $error("clock low phase too short");
  property p_exit_gap;
    $fell(master_clear_pin) |-> idle_cnt_r >= EXIT_CYC - 1;
  endproperty
  a_exit_gap: assert property (p_exit_gap) else $error("mode left without idle gap");
  property p_dev_quiet;
    !master_clear_pin |-> dev_data_oe_n;
  endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("device drives outside mode");
  property p_no_clash;
    !dev_data_oe_n |-> host_data_oe_n;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  property p_pin_dev;
    !dev_data_oe_n |-> prog_serial_data == dev_data_o;
  endproperty
  a_pin_dev: assert property (p_pin_dev) else $error("data pin not showing readout bit");
  property p_dev_len;
    $fell(dev_data_oe_n) |-> ##[124:132] $rose(dev_data_oe_n);
  endproperty
  a_dev_len: assert property (p_dev_len) else $error("readout drive not sixteen pulses");
endmodule : prog_link_assertions
`default_nettype wire

//--- prog_exec_presence_check_bench.sv
// bench: two link pairs, one holding the expected identifier and one not
`timescale 1ns/1ns
`default_nettype none
`include "prog_link_regs.svh"
module prog_exec_presence_check_bench;
  localparam logic [15:0] ID_VAL = 16'h005a; // arbitrary value
  localparam logic [15:0] ID_OTHER = 16'h0033; // arbitrary value
  localparam logic [23:0] SEQ_W [0:12] = '{`W_NOP, `W_GOTO_200, `W_NOP, `W_LD_PAGE, `W_WR_PAGE, `W_LD_OFS,
    `W_LD_PTR, `W_NOP, `W_TABLE_READ_LOW_INSTR, `W_NOP, `W_NOP, 24'h000000, `W_NOP};
  logic clk, rstn, start, nxt, start_b, nxt_b, cmd_valid, cmd_ok, prog_mode;
  logic [3:0] cmd;
  logic busy, done, resident, load_need, ram_stale, done_b, resident_b, load_b, ram_b;
  logic busy_b, cmd_ok_b, mode_b;
  logic [15:0] id_word, id_b, readout, readout_b;
  prog_link_pkg::prog_phase_t phase, phase_b;
  logic [363:0] wire_bits;
  int rise_cnt, err_count, checks;
  prog_link_if link ();
  prog_link_if link_b ();
  prog_exec_host #(.ID_EXPECTED(ID_VAL), .SETTLE_CYC(2), .EXIT_CYC(2)) u_prog_exec_host (.i_ref_clk(clk),
    .i_rstn(rstn), .i_start(start), .i_phase_next(nxt), .o_busy(busy), .o_done(done), .o_exec_resident(resident),
    .o_load_exec_needed(load_need), .o_id_word(id_word), .o_phase(phase), .o_ram_stale(ram_stale), .link(link));
  prog_exec_device #(.ID_WORD(ID_VAL)) u_prog_exec_device (.i_ref_clk(clk), .i_rstn(rstn), .link(link),
    .i_exec_cmd(cmd), .i_exec_cmd_valid(cmd_valid), .o_exec_cmd_ok(cmd_ok), .o_prog_mode(prog_mode),
    .o_readout(readout));
  prog_exec_host #(.ID_EXPECTED(ID_VAL), .SETTLE_CYC(2), .EXIT_CYC(2)) u_prog_exec_host_b (.i_ref_clk(clk),
    .i_rstn(rstn), .i_start(start_b), .i_phase_next(nxt_b), .o_busy(busy_b), .o_done(done_b),
    .o_exec_resident(resident_b), .o_load_exec_needed(load_b), .o_id_word(id_b), .o_phase(phase_b),
    .o_ram_stale(ram_b), .link(link_b));
  prog_exec_device #(.ID_WORD(ID_OTHER)) u_prog_exec_device_b (.i_ref_clk(clk), .i_rstn(rstn), .link(link_b),
    .i_exec_cmd(cmd), .i_exec_cmd_valid(cmd_valid), .o_exec_cmd_ok(cmd_ok_b), .o_prog_mode(mode_b),
    .o_readout(readout_b));
  prog_link_assertions #(.EXIT_CYC(2)) u_prog_link_assertions (.i_ref_clk(clk), .i_rstn(rstn),
    .prog_serial_clock(link.prog_serial_clock), .master_clear_pin(link.master_clear_pin),
    .host_data_o(link.host_data_o), .host_data_oe_n(link.host_data_oe_n), .dev_data_o(link.dev_data_o),
    .dev_data_oe_n(link.dev_data_oe_n), .prog_serial_data(link.prog_serial_data));

  // 25 MHz reference
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // pin level at each link clock rise, in pulse order
  always @(posedge link.prog_serial_clock) begin
    if (link.master_clear_pin) begin
      if (rise_cnt < 364) wire_bits[rise_cnt] = link.prog_serial_data;
      rise_cnt++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // full read on the matching pair, judged at the wire and the user side
  task automatic test_resident;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (20) @(posedge clk);
    check(prog_mode, 1'b1);
    check(busy, 1'b1);
    for (int i = 0; i < 6000 && done !== 1'b1; i++) @(posedge clk);
    #1;
    check(done, 1'b1);
    check(rise_cnt, 364);
    for (int f = 0; f < 13; f++)
      check(wire_bits[f*28 +: 28], f == 11 ? {ID_VAL, 8'hff, `CODE_READOUT} : {SEQ_W[f], `CODE_FORCED});
    check(id_word, ID_VAL);
    check(readout, ID_VAL);
    check(resident, 1'b1);
    check(load_need, 1'b0);
    check(phase, prog_link_pkg::PH_VERIFY_EXEC);
    check(ram_stale, 1'b0);
    check({busy, link.master_clear_pin, link.prog_serial_clock, link.prog_serial_data}, 4'h1);
    $display("resident test done");
  endtask : test_resident

  // mismatching pair: executive must be loaded, phases refused
  task automatic test_missing;
    @(posedge clk) start_b <= 1'b1;
    @(posedge clk) start_b <= 1'b0;
    for (int i = 0; i < 6000 && done_b !== 1'b1; i++) @(posedge clk);
    @(posedge clk) nxt_b <= 1'b1;
    @(posedge clk) nxt_b <= 1'b0;
    #1;
    check(done_b, 1'b1);
    check(id_b, ID_OTHER);
    check(readout_b, ID_OTHER);
    check({busy_b, mode_b}, 2'b00);
    check({resident_b, load_b}, 2'b01);
    check(phase_b, prog_link_pkg::PH_IDLE);
    check(ram_b, 1'b0);
    $display("missing test done");
  endtask : test_missing

  // phase order, one step per pulse, then held high back to back
  task automatic test_phases;
    prog_link_pkg::prog_phase_t exp_ph [0:2];
    exp_ph = '{prog_link_pkg::PH_ERASE, prog_link_pkg::PH_PROG_CODE, prog_link_pkg::PH_PROG_CONFIG};
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) nxt <= 1'b1;
      @(posedge clk) nxt <= 1'b0;
      #1;
      check(phase, exp_ph[k]);
      check(ram_stale, 1'b1);
    end
    @(posedge clk) nxt <= 1'b1;
    @(posedge clk);
    #1;
    check(phase, prog_link_pkg::PH_VERIFY_ALL);
    @(posedge clk) nxt <= 1'b0;
    #1;
    check(phase, prog_link_pkg::PH_END);
    $display("phase test done");
  endtask : test_phases

  // every command code, plus codes beyond the set and an idle request
  task automatic test_cmds;
    for (int c = 0; c < 17; c++) begin
      @(posedge clk) begin
        cmd <= c[3:0];
        cmd_valid <= (c < 16);
      end
      @(posedge clk);
      #1;
      check(cmd_ok, c < 7);
      check(cmd_ok_b, c < 7);
    end
    $display("command test done");
  endtask : test_cmds

  // watchdog, well past two link runs
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    {rstn, start, nxt, start_b, nxt_b, cmd_valid} = 6'h00;
    cmd = 4'h0;
    rise_cnt = 0;
    err_count = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    test_resident();
    test_missing();
    test_phases();
    test_cmds();
    tally_and_finish();
  end
endmodule : prog_exec_presence_check_bench
`default_nettype wire
